// ---- qps_defines.svh ----
`ifndef QPS_DEFINES_SVH
`define QPS_DEFINES_SVH

// Operation codes carried in the upper nibble of the instruction byte.
`define QPS_OP_RD_WIPER 4'h9
`define QPS_OP_WR_WIPER 4'ha
`define QPS_OP_RD_SAVED 4'hb
`define QPS_OP_WR_SAVED 4'hc
`define QPS_OP_XFER 4'hd
`define QPS_OP_INCDEC 4'h2

// Instruction byte fields.
`define QPS_OP_MSB 7
`define QPS_OP_LSB 4
`define QPS_ID_MSB 3
`define QPS_ID_LSB 2
`define QPS_POT_MSB 1
`define QPS_POT_LSB 0

// Second byte of a transfer: direction bit, 1 moves wiper into saved slot.
`define QPS_XFER_DIR_BIT 7

// Bit counter values: the last bit of each sequence, the first step bit, the read load points and the counter ceiling.
`define QPS_LAST_WR_WIPER 5'h0f
`define QPS_LAST_WR_SAVED 5'h17
`define QPS_LAST_XFER 5'h0f
`define QPS_LAST_INSTR 5'h07
`define QPS_FIRST_STEP 5'h08
`define QPS_RD_WIPER_AT 5'h08
`define QPS_RD_SAVED_AT 5'h10
`define QPS_CNT_MAX 5'h1f

// Content of the saved-setting store after every reset.
`define QPS_SAVED_RESET 8'h80

// Timing.
`define QPS_CLK_PERIOD_NS 10
`define QPS_NVWR_TIME_NS 5000000

`endif

// ---- qps_pkg.sv ----
`default_nettype none
package qps_pkg;
  `include "qps_defines.svh"

  typedef enum logic [3:0] {
    QPS_RD_WIPER = `QPS_OP_RD_WIPER,
    QPS_WR_WIPER = `QPS_OP_WR_WIPER,
    QPS_RD_SAVED = `QPS_OP_RD_SAVED,
    QPS_WR_SAVED = `QPS_OP_WR_SAVED,
    QPS_XFER = `QPS_OP_XFER,
    QPS_INCDEC = `QPS_OP_INCDEC
  } qps_op_type;

  typedef enum logic [1:0] {
    QPS_ST_RECALL,
    QPS_ST_IDLE,
    QPS_ST_NVWRITE
  } qps_state_type;
endpackage : qps_pkg
`default_nettype wire

// ---- qps_spi_control.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "qps_defines.svh"

module qps_spi_control #(
  parameter int NVWR_CYCLES = `QPS_NVWR_TIME_NS / `QPS_CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic bus_id_pin_low,
  input wire logic bus_id_pin_high,
  output logic so,
  output logic so_oe,
  output logic [7:0] wiper_setting_0,
  output logic [7:0] wiper_setting_1,
  output logic [7:0] wiper_setting_2,
  output logic [7:0] wiper_setting_3,
  output logic nv_busy
);

  localparam int CW = $clog2(NVWR_CYCLES + 1);

  function automatic logic [3:0] saved_idx(input logic [1:0] pot, input logic [1:0] slot);
    saved_idx = {pot, slot};
  endfunction : saved_idx

  function automatic logic [7:0] step(input logic [7:0] val, input logic up);
    if (up) begin
      step = (val == 8'hff) ? val : val + 8'h01;
    end else begin
      step = (val == 8'h00) ? val : val - 8'h01;
    end
  endfunction : step

  // Store, owned by the system clock domain. The link side reads it only while
  // selected; it changes only after chip select rises or during recall.
  logic [7:0] wiper_setting_reg_q [4];
  logic [7:0] wiper_setting_reg_d [4];
  logic [7:0] saved_setting_reg_q [16];
  logic [7:0] saved_setting_reg_d [16];

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, receive side, clocked by the rising serial clock.

  logic link_rst;
  logic so_rst;
  assign link_rst = sys_rst | cs_n;
  assign so_rst = link_rst | ~hold_n;

  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] instr_q, instr_d;
  logic [7:0] addr_q, addr_d;
  qps_pkg::qps_op_type cmd_op_q, cmd_op_d;
  logic [1:0] cmd_pot_q, cmd_pot_d;
  logic [1:0] cmd_slot_q, cmd_slot_d;
  logic cmd_dir_q, cmd_dir_d;
  logic [7:0] cmd_data_q, cmd_data_d;
  logic cmd_tog_q, cmd_tog_d;
  logic selected;
  qps_pkg::qps_op_type frame_op;
  logic [1:0] frame_pot;

  assign frame_op = qps_pkg::qps_op_type'(instr_q[`QPS_OP_MSB:`QPS_OP_LSB]);
  assign frame_pot = instr_q[`QPS_POT_MSB:`QPS_POT_LSB];
  assign selected = (bit_cnt_q > `QPS_LAST_INSTR) &&
                    (instr_q[`QPS_ID_MSB:`QPS_ID_LSB] == {bus_id_pin_high, bus_id_pin_low});

  always_comb begin
    logic fire;
    fire = 1'b0;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    instr_d = instr_q;
    addr_d = addr_q;
    cmd_op_d = cmd_op_q;
    cmd_pot_d = cmd_pot_q;
    cmd_slot_d = cmd_slot_q;
    cmd_dir_d = cmd_dir_q;
    cmd_data_d = cmd_data_q;
    cmd_tog_d = cmd_tog_q;
    // A held sequence freezes all progress and ignores the input pin.
    if (hold_n) begin
      shift_d = {shift_q[6:0], si};
      bit_cnt_d = (bit_cnt_q == `QPS_CNT_MAX) ? bit_cnt_q : bit_cnt_q + 5'h01;
      if (bit_cnt_q == `QPS_LAST_INSTR) begin
        instr_d = shift_d;
      end
      if (bit_cnt_q == `QPS_LAST_WR_WIPER) begin
        addr_d = shift_d;
      end
      if (selected) begin
        unique case (frame_op)
          qps_pkg::QPS_WR_WIPER: begin
            if (bit_cnt_q == `QPS_LAST_WR_WIPER) begin
              fire = 1'b1;
              cmd_data_d = shift_d;
            end
          end
          qps_pkg::QPS_WR_SAVED: begin
            if (bit_cnt_q == `QPS_LAST_WR_SAVED) begin
              fire = 1'b1;
              cmd_slot_d = addr_q[1:0];
              cmd_data_d = shift_d;
            end
          end
          qps_pkg::QPS_XFER: begin
            if (bit_cnt_q == `QPS_LAST_XFER) begin
              fire = 1'b1;
              cmd_slot_d = shift_d[1:0];
              cmd_dir_d = shift_d[`QPS_XFER_DIR_BIT];
            end
          end
          qps_pkg::QPS_INCDEC: begin
            // Each bit after the instruction, up to the 31st bit of the frame, is one step: one up, zero down.
            if (bit_cnt_q == `QPS_FIRST_STEP) begin
              fire = 1'b1;
              cmd_data_d = step(wiper_setting_reg_q[frame_pot], si);
            end else if (bit_cnt_q != `QPS_CNT_MAX) begin
              cmd_data_d = step(cmd_data_q, si);
            end
          end
          default: begin
          end
        endcase
        if (fire) begin
          cmd_op_d = frame_op;
          cmd_pot_d = frame_pot;
          cmd_tog_d = ~cmd_tog_q;
        end
      end
    end
  end

  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 8'h00;
      instr_q <= 8'h00;
      addr_q <= 8'h00;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      instr_q <= instr_d;
      addr_q <= addr_d;
    end
  end

  // The completed command survives deselection so the system side can take it.
  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_op_q <= qps_pkg::QPS_RD_WIPER;
      cmd_pot_q <= 2'h0;
      cmd_slot_q <= 2'h0;
      cmd_dir_q <= 1'b0;
      cmd_data_q <= 8'h00;
      cmd_tog_q <= 1'b0;
    end else begin
      cmd_op_q <= cmd_op_d;
      cmd_pot_q <= cmd_pot_d;
      cmd_slot_q <= cmd_slot_d;
      cmd_dir_q <= cmd_dir_d;
      cmd_data_q <= cmd_data_d;
      cmd_tog_q <= cmd_tog_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, transmit side, clocked by the falling serial clock.

  logic so_q, so_d;
  logic [6:0] rd_sh_q, rd_sh_d;
  logic reading_q, reading_d;
  logic so_oe_q;

  always_comb begin
    so_d = so_q;
    rd_sh_d = rd_sh_q;
    reading_d = reading_q;
    if (hold_n) begin
      if (selected && frame_op == qps_pkg::QPS_RD_WIPER && bit_cnt_q == `QPS_RD_WIPER_AT) begin
        {so_d, rd_sh_d} = wiper_setting_reg_q[frame_pot];
        reading_d = 1'b1;
      end else if (selected && frame_op == qps_pkg::QPS_RD_SAVED && bit_cnt_q == `QPS_RD_SAVED_AT) begin
        {so_d, rd_sh_d} = saved_setting_reg_q[saved_idx(frame_pot, addr_q[1:0])];
        reading_d = 1'b1;
      end else begin
        {so_d, rd_sh_d} = {rd_sh_q, 1'b0};
      end
    end
  end

  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      so_q <= 1'b0;
      rd_sh_q <= 7'h00;
      reading_q <= 1'b0;
    end else begin
      so_q <= so_d;
      rd_sh_q <= rd_sh_d;
      reading_q <= reading_d;
    end
  end

  // The driver re-enables on the first falling edge after a hold is released.
  always_ff @(negedge sck or posedge so_rst) begin
    if (so_rst) begin
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= reading_d;
    end
  end

  assign so = so_q;
  assign so_oe = so_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // System domain: synchronisers, commit and the write cycle.

  logic [2:0] cs_sync_q, cs_sync_d;
  logic [2:0] wp_sync_q, wp_sync_d;
  logic [2:0] tog_sync_q, tog_sync_d;
  logic cs_lvl_q, cs_lvl_d;
  logic wp_lvl_q, wp_lvl_d;
  logic seen_tog_q, seen_tog_d;
  logic pend_q, pend_d;
  logic abort_q, abort_d;
  qps_pkg::qps_state_type state_q, state_d;
  logic [CW-1:0] busy_cnt_q, busy_cnt_d;
  logic nv_busy_q, nv_busy_d;

  always_comb begin
    logic cs_rise;
    logic cs_fall;
    logic wp_fall;
    logic tog_evt;
    logic nv_go;
    cs_sync_d = {cs_sync_q[1:0], cs_n};
    wp_sync_d = {wp_sync_q[1:0], wp_n};
    tog_sync_d = {tog_sync_q[1:0], cmd_tog_q};
    cs_rise = ~cs_lvl_q & cs_sync_q[1] & cs_sync_q[2];
    cs_fall = cs_lvl_q & ~cs_sync_q[1] & ~cs_sync_q[2];
    wp_fall = wp_lvl_q & ~wp_sync_q[1] & ~wp_sync_q[2];
    tog_evt = (tog_sync_q[1] == tog_sync_q[2]) && (tog_sync_q[2] != seen_tog_q);
    cs_lvl_d = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : cs_lvl_q;
    wp_lvl_d = (wp_sync_q[1] == wp_sync_q[2]) ? wp_sync_q[2] : wp_lvl_q;
    seen_tog_d = tog_evt ? tog_sync_q[2] : seen_tog_q;
    nv_go = 1'b0;
    // A guard fall in the same cycle as a new selection does not count.
    abort_d = cs_fall ? 1'b0 : abort_q;
    if (wp_fall && !cs_lvl_q) begin
      abort_d = 1'b1;
    end
    pend_d = (pend_q | tog_evt) & ~cs_rise;
    state_d = state_q;
    busy_cnt_d = busy_cnt_q;
    nv_busy_d = nv_busy_q;
    wiper_setting_reg_d = wiper_setting_reg_q;
    saved_setting_reg_d = saved_setting_reg_q;
    unique case (state_q)
      qps_pkg::QPS_ST_RECALL: begin
        for (int i = 0; i < 4; i++) begin
          wiper_setting_reg_d[i] = saved_setting_reg_q[saved_idx(2'(i), 2'h0)];
        end
        state_d = qps_pkg::QPS_ST_IDLE;
      end
      qps_pkg::QPS_ST_IDLE: begin
        if (cs_rise && (pend_q || tog_evt) && !abort_q) begin
          unique case (cmd_op_q)
            qps_pkg::QPS_WR_WIPER, qps_pkg::QPS_INCDEC: begin
              wiper_setting_reg_d[cmd_pot_q] = cmd_data_q;
            end
            qps_pkg::QPS_WR_SAVED: begin
              if (wp_lvl_q) begin
                saved_setting_reg_d[saved_idx(cmd_pot_q, cmd_slot_q)] = cmd_data_q;
                nv_go = 1'b1;
              end
            end
            qps_pkg::QPS_XFER: begin
              if (!cmd_dir_q) begin
                wiper_setting_reg_d[cmd_pot_q] = saved_setting_reg_q[saved_idx(cmd_pot_q, cmd_slot_q)];
              end else if (wp_lvl_q) begin
                saved_setting_reg_d[saved_idx(cmd_pot_q, cmd_slot_q)] = wiper_setting_reg_q[cmd_pot_q];
                nv_go = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
        if (nv_go) begin
          state_d = qps_pkg::QPS_ST_NVWRITE;
          busy_cnt_d = '0;
          nv_busy_d = 1'b1;
        end
      end
      qps_pkg::QPS_ST_NVWRITE: begin
        // The store was updated on entry, so the guard pin cannot undo it.
        if (busy_cnt_q == CW'(NVWR_CYCLES - 1)) begin
          state_d = qps_pkg::QPS_ST_IDLE;
          nv_busy_d = 1'b0;
        end else begin
          busy_cnt_d = busy_cnt_q + CW'(1);
        end
      end
      default: begin
        state_d = qps_pkg::QPS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cs_sync_q <= 3'h7;
      wp_sync_q <= 3'h7;
      tog_sync_q <= 3'h0;
      cs_lvl_q <= 1'b1;
      wp_lvl_q <= 1'b1;
      seen_tog_q <= 1'b0;
      pend_q <= 1'b0;
      abort_q <= 1'b0;
      state_q <= qps_pkg::QPS_ST_RECALL;
      busy_cnt_q <= '0;
      nv_busy_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        wiper_setting_reg_q[i] <= `QPS_SAVED_RESET;
      end
      for (int j = 0; j < 16; j++) begin
        saved_setting_reg_q[j] <= `QPS_SAVED_RESET;
      end
    end else begin
      cs_sync_q <= cs_sync_d;
      wp_sync_q <= wp_sync_d;
      tog_sync_q <= tog_sync_d;
      cs_lvl_q <= cs_lvl_d;
      wp_lvl_q <= wp_lvl_d;
      seen_tog_q <= seen_tog_d;
      pend_q <= pend_d;
      abort_q <= abort_d;
      state_q <= state_d;
      busy_cnt_q <= busy_cnt_d;
      nv_busy_q <= nv_busy_d;
      wiper_setting_reg_q <= wiper_setting_reg_d;
      saved_setting_reg_q <= saved_setting_reg_d;
    end
  end

  // Each wiper value names the single tap connected to that wiper.
  assign wiper_setting_0 = wiper_setting_reg_q[0];
  assign wiper_setting_1 = wiper_setting_reg_q[1];
  assign wiper_setting_2 = wiper_setting_reg_q[2];
  assign wiper_setting_3 = wiper_setting_reg_q[3];
  assign nv_busy = nv_busy_q;

endmodule : qps_spi_control
`default_nettype wire

// ---- qps_spi_control_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module qps_spi_control_asserts #(
  parameter int NVWR_CYCLES = 20
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic bus_id_pin_low,
  input wire logic bus_id_pin_high,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [7:0] wiper_setting_0,
  input wire logic [7:0] wiper_setting_1,
  input wire logic [7:0] wiper_setting_2,
  input wire logic [7:0] wiper_setting_3,
  input wire logic nv_busy
);
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;
  logic [31:0] wipers;
  assign wipers = {wiper_setting_0, wiper_setting_1, wiper_setting_2, wiper_setting_3};
  always_comb begin
    busy_cnt_d = nv_busy ? busy_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clock) begin
    busy_cnt_q <= sys_rst ? 32'h0 : busy_cnt_d;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_idle_float; cs_n |-> !so_oe; endproperty
  a_idle_float: assert property (p_idle_float) else $error("so driven while deselected");
  property p_hold_float; !hold_n |-> !so_oe; endproperty
  a_hold_float: assert property (p_hold_float) else $error("so driven while paused");
  property p_so_fall; so_oe && !$stable(so) |-> !sck && $past(sck); endproperty
  a_so_fall: assert property (p_so_fall) else $error("so moved off a falling edge");
  property p_oe_start; $rose(so_oe) |-> !sck && $past(sck) && !$past(cs_n, 40); endproperty
  a_oe_start: assert property (p_oe_start) else $error("so enabled out of frame");
  property p_wiper_quiet; !$stable(wipers) |-> $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3); endproperty
  a_wiper_quiet: assert property (p_wiper_quiet) else $error("wiper moved inside a frame");
  property p_busy_start; $rose(nv_busy) |-> cs_n && $past(cs_n, 3) && $past(wp_n, 5); endproperty
  a_busy_start: assert property (p_busy_start) else $error("write cycle started wrongly");
  property p_busy_len; $fell(nv_busy) |-> busy_cnt_q == NVWR_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_busy_keep; $rose(nv_busy) |=> nv_busy [*8]; endproperty
  a_busy_keep: assert property (p_busy_keep) else $error("write cycle cut short");
endmodule : qps_spi_control_asserts

bind qps_spi_control qps_spi_control_asserts #(.NVWR_CYCLES(NVWR_CYCLES)) u_asserts (
  .clock(clock), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
  .bus_id_pin_low(bus_id_pin_low), .bus_id_pin_high(bus_id_pin_high), .so(so), .so_oe(so_oe),
  .wiper_setting_0(wiper_setting_0), .wiper_setting_1(wiper_setting_1),
  .wiper_setting_2(wiper_setting_2), .wiper_setting_3(wiper_setting_3), .nv_busy(nv_busy)
);
`default_nettype wire

// ---- qps_spi_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module qps_spi_host (
  input wire logic so,
  input wire logic so_oe,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Every edge here lands on an even nanosecond after a system clock edge, and the rising system clock edges fall on odd
  // ones, so the two never meet in one time step.
  task automatic xfer(input logic [31:0] tx, input int n, input int hold_at, output logic [31:0] rx);
    rx = 32'h0;
    #3 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #16 si = tx[31-i];
      if (i == hold_at) begin
        #8 hold_n = 1'b0;
        si = ~si;
        #48 si = ~si;
        #8 hold_n = 1'b1;
      end
      #16 sck = 1'b1;
      // A released line is read as the inverse of the last bit, never as a lucky match.
      rx = {rx[30:0], so_oe ? so : ~rx[0]};
      #32 sck = 1'b0;
    end
    #16 si = ~si;
    #16 cs_n = 1'b1;
    #100;
  endtask : xfer
endmodule : qps_spi_host
`default_nettype wire

// ---- tb_quad_pot_spi_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_quad_pot_spi_control;
  localparam int NVW = 20;
  logic clock, sys_rst, wp_n, sck, cs_n, si, hold_n, so, so_oe, nv_busy;
  logic [1:0] id, fid, sl;
  logic [7:0] v;
  logic [7:0] w [4];
  logic [7:0] exp_w [4];
  logic [7:0] exp_s [16];
  logic [31:0] rx;
  logic [15:0] bits;
  int ns, n_fail, comparisons;

  qps_spi_control #(.NVWR_CYCLES(NVW)) dut (
    .clock(clock), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .bus_id_pin_low(id[0]), .bus_id_pin_high(id[1]), .so(so), .so_oe(so_oe), .wiper_setting_0(w[0]),
    .wiper_setting_1(w[1]), .wiper_setting_2(w[2]), .wiper_setting_3(w[3]), .nv_busy(nv_busy)
  );
  qps_spi_host host (.so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task close_out;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task cmd(input logic [3:0] op, input logic [1:0] p, input logic [15:0] tail, input int n, input int hold_at);
    @(posedge clock);
    host.xfer({op, fid, p, tail, 8'h00}, n, hold_at, rx);
    repeat (2) @(posedge clock);
  endtask : cmd

  task idle;
    int k;
    k = 0;
    while (nv_busy !== 1'b0 && k < 100) begin
      @(posedge clock);
      k++;
    end
    chk("busy", nv_busy, 1'b0);
  endtask : idle

  task chk_w;
    for (int p = 0; p < 4; p++) chk("wiper", w[p], exp_w[p]);
  endtask : chk_w

  task do_reset;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 16; i++) exp_s[i] = 8'h80;
    for (int i = 0; i < 4; i++) exp_w[i] = 8'h80;
  endtask : do_reset

  function automatic logic [7:0] step(input logic [7:0] x, input logic up);
    if (up) return (x == 8'hff) ? x : x + 8'h01;
    return (x == 8'h00) ? x : x - 8'h01;
  endfunction : step

  initial begin
    sys_rst = 1'b1;
    wp_n = 1'b1;
    id = 2'b00;
    fid = 2'b00;
    n_fail = 0;
    comparisons = 0;
    rx = $urandom(32'h2512);
    @(posedge clock);
    id <= 2'($urandom);
    do_reset;
    fid = id;
    chk_w;
    $display("test recall done");
    for (int p = 0; p < 4; p++) begin
      v = 8'($urandom);
      cmd(qps_pkg::QPS_WR_WIPER, 2'(p), {v, 8'h00}, 16, (p == 1) ? 12 : -1);
      exp_w[p] = v;
      cmd(qps_pkg::QPS_RD_WIPER, 2'(p), 16'h0000, 16, (p == 2) ? 5 : -1);
      chk("rd wiper", rx[7:0], v);
    end
    chk_w;
    $display("test wiper done");
    fid = ~id;
    cmd(qps_pkg::QPS_WR_WIPER, 2'd0, 16'h5500, 16, -1);
    fid = id;
    chk_w;
    cmd(4'h0, 2'd1, 16'h5500, 16, -1);
    chk_w;
    cmd(qps_pkg::QPS_WR_WIPER, 2'd2, 16'h5500, 12, -1);
    chk_w;
    fork
      cmd(qps_pkg::QPS_WR_WIPER, 2'd3, 16'h5500, 16, -1);
      begin
        repeat (40) @(posedge clock);
        wp_n <= 1'b0;
      end
    join
    wp_n <= 1'b1;
    chk_w;
    $display("test refusal done");
    for (int p = 0; p < 4; p++) begin
      sl = 2'($urandom);
      v = 8'($urandom);
      cmd(qps_pkg::QPS_WR_SAVED, 2'(p), {6'h00, sl, v}, 24, -1);
      chk("busy", nv_busy, 1'b1);
      wp_n <= 1'b0;
      idle;
      wp_n <= 1'b1;
      exp_s[p*4+sl] = v;
      cmd(qps_pkg::QPS_RD_SAVED, 2'(p), {6'h00, sl, 8'h00}, 24, -1);
      chk("rd saved", rx[7:0], v);
    end
    @(posedge clock);
    wp_n <= 1'b0;
    v = ~exp_s[0];
    cmd(qps_pkg::QPS_WR_SAVED, 2'd0, {8'h00, v}, 24, -1);
    cmd(qps_pkg::QPS_WR_WIPER, 2'd0, {v, 8'h00}, 16, -1);
    exp_w[0] = v;
    wp_n <= 1'b1;
    chk("busy", nv_busy, 1'b0);
    cmd(qps_pkg::QPS_RD_SAVED, 2'd0, 16'h0000, 24, -1);
    chk("rd saved", rx[7:0], exp_s[0]);
    chk_w;
    $display("test saved done");
    sl = 2'($urandom);
    cmd(qps_pkg::QPS_XFER, 2'd1, {1'b1, 5'h00, sl, 8'h00}, 16, -1);
    exp_s[4+sl] = exp_w[1];
    idle;
    cmd(qps_pkg::QPS_RD_SAVED, 2'd1, {6'h00, sl, 8'h00}, 24, -1);
    chk("xfer out", rx[7:0], exp_s[4+sl]);
    cmd(qps_pkg::QPS_XFER, 2'd3, {6'h00, sl, 8'h00}, 16, -1);
    exp_w[3] = exp_s[12+sl];
    chk_w;
    for (int t = 0; t < 6; t++) begin
      v = (t == 0) ? 8'hfd : (t == 1) ? 8'h02 : 8'($urandom);
      bits = (t == 0) ? 16'hffff : (t == 1) ? 16'h0000 : 16'($urandom);
      ns = (t < 2) ? 6 : 1 + $urandom % 8;
      cmd(qps_pkg::QPS_WR_WIPER, 2'(t), {v, 8'h00}, 16, -1);
      for (int i = 0; i < ns; i++) v = step(v, bits[15-i]);
      exp_w[t%4] = v;
      cmd(qps_pkg::QPS_INCDEC, 2'(t), bits, 8 + ns, -1);
      chk_w;
    end
    $display("test transfer done");
    do_reset;
    chk_w;
    $display("test second reset done");
    close_out;
  end

  // Thirty-eight frames of at most 2.5 us each fit well inside this span, which stays below the cycle budget.
  initial begin
    #400000;
    n_fail++;
    close_out;
  end
endmodule : tb_quad_pot_spi_control
`default_nettype wire
